//--- rtl/abap_pkg.sv
// Package for the bus address select and power gating block.
// Assumes a single 200 MHz clock domain and synchronous pin inputs.
`default_nettype none
package abap_pkg;
    // Clock period in picoseconds
    localparam int unsigned CLK_PERIOD_PS    = 5000;
    // Least high time of the convert-start pulse, in nanoseconds
    localparam int unsigned CONV_START_MIN_NS = 1000;
    localparam int unsigned CONV_START_MIN_CYC =
        (CONV_START_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Wake-up time of the core, in nanoseconds
    localparam int unsigned WAKE_NS          = 1000;
    localparam int unsigned WAKE_CYC         = (WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Conversion time, in nanoseconds
    localparam int unsigned CONV_NS          = 2000;
    localparam int unsigned CONV_CYC         = (CONV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CNT_W            = 12;

    // Seven-bit bus addresses
    localparam logic [6:0] ADDR_FLOAT        = 7'h20;
    localparam logic [6:0] ADDR_V0_GND       = 7'h21;
    localparam logic [6:0] ADDR_V0_VDD       = 7'h22;
    localparam logic [6:0] ADDR_V1_GND       = 7'h23;
    localparam logic [6:0] ADDR_V1_VDD       = 7'h24;

    // Address-select pin strap encodings
    localparam logic [1:0] SEL_GND           = 2'h0;
    localparam logic [1:0] SEL_VDD           = 2'h1;
    localparam logic [1:0] SEL_FLOAT         = 2'h2;

    typedef enum logic [1:0] {
        ABAP_PWR_DOWN,
        ABAP_PWR_WAKE,
        ABAP_PWR_CONV
    } abap_pwr_type;

    typedef enum logic [2:0] {
        ABAP_BUS_IDLE,
        ABAP_BUS_ADDR,
        ABAP_BUS_ACK,
        ABAP_BUS_DATA,
        ABAP_BUS_DACK,
        ABAP_BUS_IGNORE
    } abap_bus_type;

    // Selected address from variant and strap
    function automatic logic [6:0] sel_addr(input logic variant, input logic [1:0] sel);
        logic [6:0] a;
        a = ADDR_FLOAT;
        if (sel == SEL_GND) begin
            a = variant ? ADDR_V1_GND : ADDR_V0_GND;
        end else if (sel == SEL_VDD) begin
            a = variant ? ADDR_V1_VDD : ADDR_V0_VDD;
        end
        return a;
    endfunction
endpackage
`default_nettype wire

//--- rtl/abap_power_seq.sv
// Power sequencer: wakes the converter core per conversion, then powers down.
// Assumes start requests are one-cycle pulses in the same clock domain.
`default_nettype none
module abap_power_seq
    import abap_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    input  wire logic wake_i,
    input  wire logic start_i,
    output logic      powered_o,
    output logic      busy_o,
    output logic      done_o
);
    abap_pwr_type     st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             done_q, done_d;

    // Next state: wake, settle, convert, then back to sleep
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        done_d = 1'b0;
        case (st_q)
            ABAP_PWR_DOWN: begin
                if (start_i) begin
                    st_d  = ABAP_PWR_WAKE;
                    cnt_d = CNT_W'(WAKE_CYC - 1);
                end else if (wake_i) begin
                    st_d  = ABAP_PWR_WAKE;
                    cnt_d = CNT_W'(WAKE_CYC - 1);
                end
            end
            ABAP_PWR_WAKE: begin
                // A pin-driven wake waits for the start edge; command starts run on
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end
                if (start_i || (cnt_q == '0 && !wake_i)) begin
                    st_d  = ABAP_PWR_CONV;
                    cnt_d = CNT_W'(CONV_CYC - 1);
                end
            end
            ABAP_PWR_CONV: begin
                if (cnt_q == '0) begin
                    st_d   = ABAP_PWR_DOWN;
                    done_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: st_d = ABAP_PWR_DOWN;
        endcase
    end

    // Registers start powered down
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q   <= ABAP_PWR_DOWN;
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign powered_o = (st_q != ABAP_PWR_DOWN);
    assign busy_o    = (st_q == ABAP_PWR_CONV);
    assign done_o    = done_q;

    property p_no_wake_unasked;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (st_q == ABAP_PWR_DOWN && !start_i && !wake_i) |=> st_q == ABAP_PWR_DOWN;
    endproperty
    a_no_wake_unasked: assert property (p_no_wake_unasked) else $error("woke unasked");

    property p_sleep_after_conv;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (st_q == ABAP_PWR_CONV && cnt_q == '0) |=> (st_q == ABAP_PWR_DOWN && done_q);
    endproperty
    a_sleep_after_conv: assert property (p_sleep_after_conv) else $error("no power down");
endmodule
`default_nettype wire

//--- rtl/abap_top.sv
// Bus address select, bus slave front end and conversion start control.
// Assumes SCL and SDA are synchronous to ref_clk_i and much slower than it.
// Overview of operation
// - Floating address-select pin gives address 010 0000 on either variant.
// - First variant: grounded pin 010 0001, supply-tied pin 010 0010.
// - Second variant: grounded pin 010 0011, supply-tied pin 010 0100.
// - After power-on the converter stays powered down until a conversion is asked.
// - Power up before each conversion, power down when it completes.
// - Start by convert-start pulse, automatic interval, or bus write-address command.
// - Bus writes work while the converter core sleeps; a read address is acknowledged but no data is driven.
// - Convert-start rise wakes, fall converts; high under 1 us flags invalid.
`default_nettype none
module abap_top
    import abap_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       variant_i,
    input  wire logic [1:0] address_select_pin_i,
    input  wire logic       convert_start_pin_i,
    input  wire logic       auto_cycle_en_i,
    input  wire logic [15:0] auto_interval_i,
    input  wire logic       cmd_mode_en_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic            powered_o,
    output logic            busy_o,
    output logic            conv_done_o,
    output logic            result_invalid_o,
    output logic [6:0]      bus_addr_o,
    output logic [7:0]      rx_byte_o,
    output logic            rx_valid_o
);
    // Strap capture registers
    logic [6:0]  addr_q, addr_d;
    logic        strap_done_q;
    // Pin edge and pulse width tracking, automatic interval timer
    logic        cs_q;
    logic [CNT_W-1:0] hi_q, hi_d;
    logic        inval_q, inval_d;
    logic [15:0] tmr_q, tmr_d;
    // Bus state
    abap_bus_type bst_q, bst_d;
    logic        scl_q, sda_q;
    logic [7:0]  sh_q, sh_d;
    logic [3:0]  bit_q, bit_d;
    logic        rw_q, rw_d;
    logic        oe_q, oe_d;
    logic [7:0]  rx_q, rx_d;
    logic        rxv_q, rxv_d;
    logic        cmd_wake_q, cmd_wake_d;
    logic        cmd_go_q, cmd_go_d;
    // Sequencer links and bus edge detects
    logic        seq_start, seq_wake, seq_pwr, seq_busy, seq_done;
    logic        pwr_q, busy_q, done_q;
    logic        scl_rise, scl_fall, start_c, stop_c;

    assign scl_rise = scl_i && !scl_q;
    assign scl_fall = !scl_i && scl_q;
    assign start_c  = scl_i && scl_q && sda_q && !sda_i;
    assign stop_c   = scl_i && scl_q && !sda_q && sda_i;

    // Address is caught on the first clock after reset release, as a strap
    always_comb begin
        addr_d = addr_q;
        if (!strap_done_q) begin
            addr_d = sel_addr(variant_i, address_select_pin_i);
        end
    end

    // Convert-start pulse width check and automatic interval
    always_comb begin
        hi_d    = hi_q;
        inval_d = inval_q;
        tmr_d   = tmr_q;
        if (convert_start_pin_i) begin
            if (!cs_q) begin
                hi_d = '0;
            end else if (hi_q != '1) begin
                hi_d = hi_q + 1'b1;
            end
        end
        if (cs_q && !convert_start_pin_i) begin
            // Count holds cycles past the rise, so add one for the rise cycle
            inval_d = (32'(hi_q) + 1) < CONV_START_MIN_CYC;
        end
        if (!auto_cycle_en_i || tmr_q == '0) begin
            tmr_d = auto_interval_i;
        end else begin
            tmr_d = tmr_q - 1'b1;
        end
    end

    // Wake while the pin is high or on a command write address; start on fall, command or automatic interval
    assign seq_wake  = convert_start_pin_i || cmd_wake_q;
    assign seq_start = (cs_q && !convert_start_pin_i) || cmd_go_q
                       || (auto_cycle_en_i && auto_interval_i != '0 && tmr_q == '0);

    // Bus slave: the address phase never consults the power state
    always_comb begin
        bst_d      = bst_q;
        sh_d       = sh_q;
        bit_d      = bit_q;
        rw_d       = rw_q;
        oe_d       = oe_q;
        rx_d       = rx_q;
        rxv_d      = 1'b0;
        cmd_wake_d = 1'b0;
        cmd_go_d   = 1'b0;
        if (start_c) begin
            bst_d = ABAP_BUS_ADDR;
            bit_d = '0;
            oe_d  = 1'b0;
        end else if (stop_c) begin
            bst_d = ABAP_BUS_IDLE;
            oe_d  = 1'b0;
        end else begin
            case (bst_q)
                ABAP_BUS_IDLE: oe_d = 1'b0;
                ABAP_BUS_ADDR: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda_i};
                        bit_d = bit_q + 1'b1;
                    end
                    if (scl_fall && bit_q == 4'h8) begin
                        if (sh_q[7:1] == addr_q) begin
                            bst_d   = ABAP_BUS_ACK;
                            oe_d    = 1'b1;
                            rw_d    = sh_q[0];
                            // Command mode wakes and converts during write address
                            cmd_wake_d = cmd_mode_en_i && !sh_q[0];
                            cmd_go_d   = cmd_mode_en_i && !sh_q[0];
                        end else begin
                            bst_d = ABAP_BUS_IGNORE;
                        end
                    end
                end
                ABAP_BUS_ACK, ABAP_BUS_DACK: begin
                    if (scl_fall) begin
                        oe_d  = 1'b0;
                        bit_d = '0;
                        bst_d = rw_q ? ABAP_BUS_IGNORE : ABAP_BUS_DATA;
                    end
                end
                ABAP_BUS_DATA: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda_i};
                        bit_d = bit_q + 1'b1;
                    end
                    if (scl_fall && bit_q == 4'h8) begin
                        bst_d   = ABAP_BUS_DACK;
                        oe_d    = 1'b1;
                        rx_d    = sh_q;
                        rxv_d   = 1'b1;
                    end
                end
                ABAP_BUS_IGNORE: oe_d = 1'b0;
                default: begin
                    bst_d = ABAP_BUS_IDLE;
                    oe_d  = 1'b0;
                end
            endcase
        end
    end

    abap_power_seq u_seq (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .wake_i    (seq_wake),
        .start_i   (seq_start),
        .powered_o (seq_pwr),
        .busy_o    (seq_busy),
        .done_o    (seq_done)
    );

    // All state registers; outputs other than sda_o come straight from these
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_q       <= ADDR_FLOAT;
            strap_done_q <= 1'b0;
            cs_q         <= 1'b0;
            hi_q         <= '0;
            inval_q      <= 1'b0;
            tmr_q        <= '0;
            bst_q        <= ABAP_BUS_IDLE;
            scl_q        <= 1'b1;
            sda_q        <= 1'b1;
            sh_q         <= '0;
            bit_q        <= '0;
            rw_q         <= 1'b0;
            oe_q         <= 1'b0;
            rx_q         <= '0;
            rxv_q        <= 1'b0;
            cmd_wake_q   <= 1'b0;
            cmd_go_q     <= 1'b0;
            pwr_q        <= 1'b0;
            busy_q       <= 1'b0;
            done_q       <= 1'b0;
        end else begin
            addr_q       <= addr_d;
            strap_done_q <= 1'b1;
            cs_q         <= convert_start_pin_i;
            hi_q         <= hi_d;
            inval_q      <= inval_d;
            tmr_q        <= tmr_d;
            bst_q        <= bst_d;
            scl_q        <= scl_i;
            sda_q        <= sda_i;
            sh_q         <= sh_d;
            bit_q        <= bit_d;
            rw_q         <= rw_d;
            oe_q         <= oe_d;
            rx_q         <= rx_d;
            rxv_q        <= rxv_d;
            cmd_wake_q   <= cmd_wake_d;
            cmd_go_q     <= cmd_go_d;
            pwr_q        <= seq_pwr;
            busy_q       <= seq_busy;
            done_q       <= seq_done;
        end
    end

    assign sda_o            = 1'b0; // Open drain: only ever pulls low
    assign sda_oe_o         = oe_q;
    assign powered_o        = pwr_q;
    assign busy_o           = busy_q;
    assign conv_done_o      = done_q;
    assign result_invalid_o = inval_q;
    assign bus_addr_o       = addr_q;
    assign rx_byte_o        = rx_q;
    assign rx_valid_o       = rxv_q;

    // Reset is sampled in each address antecedent so the release edge starts no attempt
    property p_addr_float;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (resetn_i && !strap_done_q && address_select_pin_i == SEL_FLOAT)
            |=> addr_q == ADDR_FLOAT;
    endproperty
    a_addr_float: assert property (p_addr_float) else $error("float address wrong");

    property p_addr_v0;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (resetn_i && !strap_done_q && !variant_i && address_select_pin_i == SEL_GND)
            |=> addr_q == ADDR_V0_GND;
    endproperty
    a_addr_v0: assert property (p_addr_v0) else $error("first variant address wrong");

    property p_addr_v1;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (resetn_i && !strap_done_q && variant_i && address_select_pin_i == SEL_VDD)
            |=> addr_q == ADDR_V1_VDD;
    endproperty
    a_addr_v1: assert property (p_addr_v1) else $error("second variant address wrong");

    property p_nack_mismatch;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (bst_q == ABAP_BUS_IGNORE) |-> !sda_oe_o;
    endproperty
    a_nack_mismatch: assert property (p_nack_mismatch) else $error("drove on mismatch");

    property p_ack_while_asleep;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (bst_q == ABAP_BUS_ADDR && scl_fall && bit_q == 4'h8 && sh_q[7:1] == addr_q
         && !start_c && !stop_c) |=> sda_oe_o;
    endproperty
    a_ack_while_asleep: assert property (p_ack_while_asleep) else $error("no ack");

    property p_pin_wakes;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        ($rose(convert_start_pin_i) && !busy_o) |-> ##[1:3] powered_o;
    endproperty
    a_pin_wakes: assert property (p_pin_wakes) else $error("pin did not wake");

    property p_cmd_start;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        cmd_go_q && !seq_pwr |-> ##[1:3] powered_o;
    endproperty
    a_cmd_start: assert property (p_cmd_start) else $error("command did not start");

    // At the fall the high time is the count sampled one edge earlier plus two
    property p_short_pulse;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $fell(convert_start_pin_i) && $past(cs_q)
        && (32'($past(hi_q)) + 2 < CONV_START_MIN_CYC) |=> result_invalid_o;
    endproperty
    a_short_pulse: assert property (p_short_pulse) else $error("short pulse not flagged");
endmodule
`default_nettype wire

//--- verification/abap_bus_master.sv
// Bus master model: drives SCL and its own SDA pull-down, one address and one byte.
// Assumes the bench resolves SDA as an open-drain wire with a pull-up.
`default_nettype none
module abap_bus_master (
    input  wire logic ref_clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idles released
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    // Data changes only mid-low so no edge looks like a START or STOP
    task automatic send_bit(input logic b, output logic seen);
        @(posedge ref_clk_i) scl_o <= 1'b0;
        tick(4);
        sda_o <= b;
        tick(4);
        scl_o <= 1'b1;
        tick(8);
        seen = sda_i;
    endtask

    // START, address with R/W bit, ACK, one byte, ACK, STOP
    // On a read the byte is still clocked out, as the slave never drives data
    task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] d,
                        output logic a_ack, output logic d_ack);
        logic s;
        logic [7:0] ab;
        ab = {a, rd};
        @(posedge ref_clk_i) sda_o <= 1'b0;
        tick(8);
        for (int i = 7; i >= 0; i--) send_bit(ab[i], s);
        send_bit(1'b1, s);
        a_ack = ~s;
        for (int i = 7; i >= 0; i--) send_bit(d[i], s);
        send_bit(1'b1, s);
        d_ack = ~s;
        @(posedge ref_clk_i) scl_o <= 1'b0;
        tick(4);
        sda_o <= 1'b0;
        tick(4);
        scl_o <= 1'b1;
        tick(4);
        sda_o <= 1'b1;
        tick(8);
    endtask
endmodule
`default_nettype wire

//--- verification/abap_top_tb_top.sv
// Self-checking bench for the address select and power gating block.
// Assumes the bus master model beside it and a 200 MHz reference clock.
`default_nettype none
module abap_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import abap_pkg::*;

    logic        ref_clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        variant_i = 1'b0;
    logic [1:0]  sel = 2'h2;
    logic        cs = 1'b0;
    logic        auto_en = 1'b0;
    logic [15:0] interval = 16'h0;
    logic        cmd_en = 1'b0;
    logic        scl, m_sda, sda_o, sda_oe_o, powered_o, busy_o, done_o, inv_o, rxv;
    logic [6:0]  bus_addr_o;
    logic [7:0]  rx_byte_o;
    wire         sda_w;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          done_cnt = 0;
    int          oe_cnt = 0;
    int          rxv_cnt = 0;
    int          cyc = 0;

    // Open-drain wire: either party may pull low
    assign sda_w = m_sda & ~(sda_oe_o & ~sda_o);

    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    abap_top u_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .variant_i(variant_i),
        .address_select_pin_i(sel), .convert_start_pin_i(cs), .auto_cycle_en_i(auto_en),
        .auto_interval_i(interval), .cmd_mode_en_i(cmd_en), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .powered_o(powered_o), .busy_o(busy_o),
        .conv_done_o(done_o), .result_invalid_o(inv_o), .bus_addr_o(bus_addr_o),
        .rx_byte_o(rx_byte_o), .rx_valid_o(rxv));

    abap_bus_master u_master (.ref_clk_i(ref_clk_i), .sda_i(sda_w), .scl_o(scl),
        .sda_o(m_sda));

    // Pulse and drive counters; also cuts a hang short
    always @(posedge ref_clk_i) begin
        cyc++;
        if (done_o === 1'b1) done_cnt++;
        if (sda_oe_o === 1'b1) oe_cnt++;
        if (rxv === 1'b1) rxv_cnt++;
        if (cyc == 40000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Address implied by variant and strap; code 3 counts as floating
    function automatic logic [6:0] exp_addr(input logic v, input logic [1:0] s);
        if (s[1]) return 7'h20;
        return 7'h21 + {5'h0, v, s[0]};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic do_reset(input logic v, input logic [1:0] s);
        @(posedge ref_clk_i) resetn_i <= 1'b0;
        variant_i <= v;
        sel <= s;
        tick(2);
        resetn_i <= 1'b1;
        tick(3);
    endtask

    // Holds convert-start high for hi cycles, then follows the conversion
    task automatic conv_pulse(input int hi, input logic exp_inv);
        int n0;
        n0 = done_cnt;
        @(posedge ref_clk_i) cs <= 1'b1;
        tick(10);
        check("wake on rise", powered_o, 1'b1);
        tick(hi - 10);
        cs <= 1'b0;
        for (int i = 0; i < 20 && busy_o !== 1'b1; i++) @(posedge ref_clk_i);
        check("busy after fall", busy_o, 1'b1);
        check("awake while busy", powered_o, 1'b1);
        for (int i = 0; i < 600 && done_cnt == n0; i++) @(posedge ref_clk_i);
        check("one done", 16'(done_cnt - n0), 16'h1);
        tick(5);
        check("asleep after", powered_o, 1'b0);
        check("invalid flag", inv_o, exp_inv);
    endtask

    initial begin
        logic aa, da;
        logic [7:0] d;
        logic [6:0] wa;
        int n0;
        int r0;
        void'($urandom(32'h86bc86dc));
        tick(2);
        resetn_i <= 1'b1;
        // Every variant and strap, with a matching and a stray address
        for (int k = 0; k < 8; k++) begin
            do_reset(k[2], k[1:0]);
            check("power-on", powered_o, 1'b0);
            check("address", bus_addr_o, exp_addr(k[2], k[1:0]));
            d = 8'($urandom);
            r0 = rxv_cnt;
            u_master.xfer(exp_addr(k[2], k[1:0]), 1'b0, d, aa, da);
            check("addr ack", aa, 1'b1);
            check("data ack", da, 1'b1);
            check("rx byte", rx_byte_o, d);
            check("rx valid", 16'(rxv_cnt - r0), 16'h1);
            check("asleep on bus", powered_o, 1'b0);
            wa = exp_addr(k[2], k[1:0]) ^ (7'h01 << ($urandom % 7));
            n0 = oe_cnt;
            r0 = rxv_cnt;
            u_master.xfer(wa, 1'b0, 8'($urandom), aa, da);
            check("stray ack", aa, 1'b0);
            check("stray data ack", da, 1'b0);
            check("stray drive", 16'(oe_cnt - n0), 16'h0);
            check("stray rx valid", 16'(rxv_cnt - r0), 16'h0);
        end
        tick(400);
        check("no self start", 16'(done_cnt), 16'h0);
        conv_pulse(200, 1'b0);
        conv_pulse(199, 1'b1);
        conv_pulse(10 + $urandom % 150, 1'b1);
        conv_pulse(200 + $urandom % 100, 1'b0);
        // Command mode: a read address must not start, a matching write address must
        n0 = done_cnt;
        cmd_en <= 1'b1;
        u_master.xfer(bus_addr_o, 1'b1, 8'h00, aa, da);
        check("read ack", aa, 1'b1);
        check("read not driven", da, 1'b0);
        check("read no start", powered_o, 1'b0);
        u_master.xfer(bus_addr_o, 1'b0, 8'h00, aa, da);
        for (int i = 0; i < 800 && done_cnt == n0; i++) @(posedge ref_clk_i);
        check("command start", 16'(done_cnt - n0), 16'h1);
        cmd_en <= 1'b0;
        tick(5);
        check("command sleep", powered_o, 1'b0);
        // Automatic interval starts, then disabled by a zero interval
        n0 = done_cnt;
        interval <= 16'd1000;
        auto_en <= 1'b1;
        tick(3000);
        check("auto starts", 16'(done_cnt - n0 >= 2), 16'h1);
        interval <= 16'h0;
        tick(700);
        n0 = done_cnt;
        tick(1500);
        check("auto off", 16'(done_cnt - n0), 16'h0);
        auto_en <= 1'b0;
        test_done();
    end
endmodule
`default_nettype wire
